// file: rce_defines.svh
// Offsets, field positions and reset values of the receive enable bank
`ifndef RCE_DEFINES_SVH
`define RCE_DEFINES_SVH

// ==========================================================================
// Bus geometry
`define RCE_ADDR_W         8
`define RCE_DATA_W         32
`define RCE_NUM_PARTS      8
`define RCE_BITS_PER_PART  16

// ==========================================================================
// Register byte offsets
`define RCE_OFF_PART_A     8'h00
`define RCE_OFF_PART_H     8'h1C
`define RCE_OFF_CTRL       8'h20
`define RCE_OFF_STAT       8'h24

// ==========================================================================
// Control register fields
`define RCE_CTRL_SEL_BIT   0
`define RCE_CTRL_EXT_BIT   1
`define RCE_CTRL_ASEL_LSB  4
`define RCE_CTRL_BSEL_LSB  6

// ==========================================================================
// Status register fields
`define RCE_STAT_EN_BIT    0
`define RCE_STAT_CHAN_LSB  8

// ==========================================================================
// Reset values
`define RCE_PART_RESET     16'h0000
`define RCE_CTRL_RESET     1'b0
`define RCE_BSEL_RESET     2'h0

`endif

// file: rce_pkg.sv
// Types shared by the receive channel enable bank
package rce_pkg;

    // One partition register and the whole bank of eight
    typedef logic [15:0]      rce_word_t;
    typedef logic [7:0][15:0] rce_bank_t;
    typedef logic [6:0]       rce_chan_t;
    typedef logic [1:0]       rce_bsel_t;

    // Decoded register slot of an APB address
    typedef enum logic [3:0] {
        RCE_SLOT_PART = 4'b0000,
        RCE_SLOT_CTRL = 4'b0001,
        RCE_SLOT_STAT = 4'b0010,
        RCE_SLOT_NONE = 4'b0011
    } rce_slot_e;

    // Complete state of the bank
    typedef struct packed {
        rce_bank_t   bank;
        logic        multichan_sel;
        logic        count_extend;
        rce_bsel_t   part_a_sel;
        rce_bsel_t   part_b_sel;
        logic [31:0] rdata;
        logic        chan_en;
        rce_chan_t   chan_num;
    } rce_state_s;

endpackage

// file: rce_chan_lookup.sv
// Maps a received channel number onto its enable bit in the bank
`timescale 1ns/1ps

module rce_chan_lookup (
    // Query valid for the channel under test
    input  wire logic             chan,
    // Mode settings
    input  wire logic             multichan_sel,
    input  wire logic             count_extend,
    input  wire rce_pkg::rce_bsel_t part_a_sel,
    input  wire rce_pkg::rce_bsel_t part_b_sel,
    // Enable bits and channel number
    input  wire rce_pkg::rce_bank_t bank,
    input  wire rce_pkg::rce_chan_t chan_num,
    // Result
    output logic                  chan_en
);
    import rce_pkg::*;

    logic [2:0] blk;
    logic [3:0] bit_idx;

    // ======================================================================
    // Channel to bit decode
    assign blk     = chan_num[6:4];
    assign bit_idx = chan_num[3:0];

    // Without selection mode every channel passes and the bank is unused
    always_comb begin
        chan_en = 1'b0;
        if (!chan) begin
            chan_en = 1'b0;
        end else if (!multichan_sel) begin
            chan_en = 1'b1;                                    // RQ2
        end else if (count_extend) begin
            chan_en = bank[blk][bit_idx];                      // RQ8
        end else if (blk == {part_a_sel, 1'b0}) begin
            chan_en = bank[0][bit_idx];                        // RQ6
        end else if (blk == {part_b_sel, 1'b1}) begin
            chan_en = bank[1][bit_idx];                        // RQ7
        end else begin
            // Partitions C..H play no part with 32 channels
            chan_en = 1'b0;                                    // RQ9
        end
    end
endmodule

// file: rce_bank.sv
// APB register bank of eight receive channel enable registers
//
// Contract
// RQ1: There are eight enable registers, one for each partition A to H.
// RQ2: The bank is consulted only while multichannel selection is set.
// RQ3: Each register holds 16 bits; 0 disables and 1 enables a channel.
// RQ4: All bits are software readable and writable and reset to zero.
// RQ5: Count extension 0 gives 32 selectable channels, 1 gives 128.
// RQ6: With 32 channels, A bit k is channel n+k of the block chosen for A.
// RQ7: With 32 channels, B bit k is channel m+k of the block chosen for B.
// RQ8: With 128 channels, register b bit k is channel 16*b+k.
// RQ9: With 32 channels, registers C to H never enable a channel.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "rce_defines.svh"

module rce_bank (
    // Clock and reset
    input  wire logic                    MCLK,
    input  wire logic                    RST_N,
    // APB slave
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [7:0]              PADDR,
    input  wire logic [31:0]             PWDATA,
    input  wire logic [3:0]              PSTRB,
    output logic                         PREADY,
    output logic [31:0]                  PRDATA,
    output logic                         PSLVERR,
    // Channel query from the receive channel counter
    input  wire logic                    RX_CHAN_VALID,
    input  wire rce_pkg::rce_chan_t      RX_CHAN_NUM,
    output logic                         RX_CHAN_ENABLED
);
    import rce_pkg::*;

    rce_state_s st_reg;
    rce_state_s st_next;
    rce_slot_e  slot;
    logic [2:0] part_idx;
    logic       lookup_en;
    logic       setup_ph;
    logic       access_ph;
    logic       wr_fire;
    logic [31:0] rd_value;
    rce_word_t  wr_word;

    // ======================================================================
    // Address decode
    // Each register takes one aligned word; misaligned addresses are
    // treated as unmapped so a stray byte pointer cannot alias a register
    always_comb begin
        slot     = RCE_SLOT_NONE;
        part_idx = PADDR[4:2];
        if (PADDR[1:0] != 2'h0) begin
            slot = RCE_SLOT_NONE;
        end else if (PADDR <= `RCE_OFF_PART_H) begin
            slot = RCE_SLOT_PART;                              // RQ1
        end else if (PADDR == `RCE_OFF_CTRL) begin
            slot = RCE_SLOT_CTRL;
        end else if (PADDR == `RCE_OFF_STAT) begin
            slot = RCE_SLOT_STAT;
        end else begin
            slot = RCE_SLOT_NONE;
        end
    end

    // ======================================================================
    // APB phases
    assign setup_ph  = PSEL & ~PENABLE;
    assign access_ph = PSEL & PENABLE;
    assign wr_fire   = access_ph & PWRITE;

    // Zero wait states: every access phase completes at once
    assign PREADY  = access_ph;
    assign PSLVERR = access_ph & (slot == RCE_SLOT_NONE);
    assign PRDATA  = st_reg.rdata;

    // ======================================================================
    // Write data merge
    // Only byte lanes 0 and 1 carry register bits; upper lanes are dropped
    always_comb begin
        wr_word = st_reg.bank[part_idx];
        if (PSTRB[0]) begin
            wr_word[7:0] = PWDATA[7:0];
        end
        if (PSTRB[1]) begin
            wr_word[15:8] = PWDATA[15:8];
        end
    end

    // ======================================================================
    // Read value mux
    // Unused upper bits read as zero
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (slot)
            RCE_SLOT_PART: begin
                rd_value[15:0] = st_reg.bank[part_idx];        // RQ4
            end
            RCE_SLOT_CTRL: begin
                rd_value[`RCE_CTRL_SEL_BIT] = st_reg.multichan_sel;
                rd_value[`RCE_CTRL_EXT_BIT] = st_reg.count_extend;
                rd_value[`RCE_CTRL_ASEL_LSB +: 2] = st_reg.part_a_sel;
                rd_value[`RCE_CTRL_BSEL_LSB +: 2] = st_reg.part_b_sel;
            end
            RCE_SLOT_STAT: begin
                rd_value[`RCE_STAT_EN_BIT] = st_reg.chan_en;
                rd_value[`RCE_STAT_CHAN_LSB +: 7] = st_reg.chan_num;
            end
            RCE_SLOT_NONE: begin
                rd_value = 32'h0000_0000;
            end
        endcase
    end

    // ======================================================================
    // Channel lookup
    rce_chan_lookup u_lookup (
        .chan          (RX_CHAN_VALID),
        .multichan_sel (st_reg.multichan_sel),
        .count_extend  (st_reg.count_extend),                  // RQ5
        .part_a_sel    (st_reg.part_a_sel),
        .part_b_sel    (st_reg.part_b_sel),
        .bank          (st_reg.bank),
        .chan_num      (RX_CHAN_NUM),
        .chan_en       (lookup_en)
    );

    assign RX_CHAN_ENABLED = st_reg.chan_en;

    // ======================================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        // Read data is captured in the setup cycle so it is a flop output
        // by the access cycle, trading one register for zero wait states
        if (setup_ph) begin
            st_next.rdata = PWRITE ? 32'h0000_0000 : rd_value;
        end
        // Writes land only at the completing access edge
        if (wr_fire) begin
            unique case (slot)
                RCE_SLOT_PART: begin
                    st_next.bank[part_idx] = wr_word;          // RQ3
                end
                RCE_SLOT_CTRL: begin
                    if (PSTRB[0]) begin
                        st_next.multichan_sel =
                            PWDATA[`RCE_CTRL_SEL_BIT];
                        st_next.count_extend =
                            PWDATA[`RCE_CTRL_EXT_BIT];
                        st_next.part_a_sel =
                            PWDATA[`RCE_CTRL_ASEL_LSB +: 2];
                        st_next.part_b_sel =
                            PWDATA[`RCE_CTRL_BSEL_LSB +: 2];
                    end
                end
                RCE_SLOT_STAT: begin
                    st_next.rdata = st_reg.rdata;              // Read only
                end
                RCE_SLOT_NONE: begin
                    st_next.rdata = st_reg.rdata;
                end
            endcase
        end
        // Enable answer follows the query one clock later
        if (RX_CHAN_VALID) begin
            st_next.chan_en  = lookup_en;
            st_next.chan_num = RX_CHAN_NUM;
        end else begin
            st_next.chan_en  = 1'b0;
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            for (int i = 0; i < `RCE_NUM_PARTS; i++) begin
                st_reg.bank[i] <= `RCE_PART_RESET;             // RQ4
            end
            st_reg.multichan_sel <= `RCE_CTRL_RESET;
            st_reg.count_extend  <= `RCE_CTRL_RESET;
            st_reg.part_a_sel    <= `RCE_BSEL_RESET;
            st_reg.part_b_sel    <= `RCE_BSEL_RESET;
            st_reg.rdata         <= 32'h0000_0000;
            st_reg.chan_en       <= 1'b0;
            st_reg.chan_num      <= 7'h00;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// file: rce_bank_props.sv
// Port checker for the receive channel enable bank
`timescale 1ns/1ps

module rce_bank_props (
    // Clock, reset and APB
    input wire logic               MCLK,
    input wire logic               RST_N,
    input wire logic               PSEL,
    input wire logic               PENABLE,
    input wire logic               PWRITE,
    input wire logic [7:0]         PADDR,
    input wire logic [31:0]        PWDATA,
    input wire logic [3:0]         PSTRB,
    input wire logic               PREADY,
    input wire logic [31:0]        PRDATA,
    input wire logic               PSLVERR,
    // Channel query
    input wire logic               RX_CHAN_VALID,
    input wire rce_pkg::rce_chan_t RX_CHAN_NUM,
    input wire logic               RX_CHAN_ENABLED
);
    import rce_pkg::*;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // ====
    // Shadow state, fed only by accepted writes
    rce_bank_t  bank_reg;
    logic [7:0] ctrl_reg;
    logic       acc;
    logic       part;
    logic       q32;
    logic [2:0] blk;
    logic       hit_any;
    logic       hit_a;
    logic       hit_b;
    // Decode helpers; a query sees the bank before a same-cycle write
    assign acc     = PSEL && PENABLE;
    assign part    = PADDR < 8'h20 && PADDR[1:0] == 2'h0;
    assign q32     = RX_CHAN_VALID && ctrl_reg[1:0] == 2'h1;
    assign blk     = RX_CHAN_NUM[6:4];
    assign hit_any = bank_reg[blk][RX_CHAN_NUM[3:0]];
    assign hit_a   = bank_reg[0][RX_CHAN_NUM[3:0]];
    assign hit_b   = bank_reg[1][RX_CHAN_NUM[3:0]];
    // Shadow registers follow byte lanes like the bank does
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            bank_reg <= '0;
            ctrl_reg <= 8'h00;
        end else if (acc && PWRITE && part) begin
            if (PSTRB[0]) bank_reg[PADDR[4:2]][7:0] <= PWDATA[7:0];
            if (PSTRB[1]) bank_reg[PADDR[4:2]][15:8] <= PWDATA[15:8];
        end else if (acc && PWRITE && PADDR == 8'h20 && PSTRB[0]) begin
            ctrl_reg <= PWDATA[7:0] & 8'hF3;
        end
    end
    // ====
    // Assertions
    AST_SEL_OFF: assert property (RX_CHAN_VALID && !ctrl_reg[0]
        |=> RX_CHAN_ENABLED) else $error("channel off without selection");
    AST_MAP_128: assert property (RX_CHAN_VALID && ctrl_reg[1:0] == 2'h3
        |=> RX_CHAN_ENABLED == $past(hit_any)) else $error("wide map wrong");
    AST_MAP_A: assert property (q32 && blk == {ctrl_reg[5:4], 1'b0}
        |=> RX_CHAN_ENABLED == $past(hit_a)) else $error("block A wrong");
    AST_MAP_B: assert property (q32 && blk == {ctrl_reg[7:6], 1'b1}
        |=> RX_CHAN_ENABLED == $past(hit_b)) else $error("block B wrong");
    AST_OUTSIDE: assert property (q32 && blk != {ctrl_reg[5:4], 1'b0}
        && blk != {ctrl_reg[7:6], 1'b1} |=> !RX_CHAN_ENABLED)
        else $error("channel outside A and B enabled");
    AST_IDLE: assert property (!RX_CHAN_VALID |=> !RX_CHAN_ENABLED)
        else $error("answer without query");
    AST_RESET: assert property ($rose(RST_N) |-> PRDATA == 32'h0
        && !RX_CHAN_ENABLED) else $error("outputs not cleared by reset");
    AST_READ: assert property (acc && !PWRITE && part
        |-> PRDATA == {16'h0000, bank_reg[PADDR[4:2]]})
        else $error("read data differs from written bits");
    AST_UNMAPPED: assert property (acc && PADDR > 8'h24
        |-> PSLVERR && PREADY) else $error("unmapped access not refused");
    // Main scenarios reached
    cover property (q32 && hit_a);
    cover property (RX_CHAN_VALID && ctrl_reg[1:0] == 2'h3 && blk == 3'h7);
    cover property (acc && PSLVERR);
endmodule

bind rce_bank rce_bank_props props_u (.MCLK, .RST_N, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PSTRB, .PREADY, .PRDATA, .PSLVERR,
    .RX_CHAN_VALID, .RX_CHAN_NUM, .RX_CHAN_ENABLED);

// file: rce_bank_test.sv
// Self-checking bench for the receive channel enable bank
`timescale 1ns/1ps

module rce_bank_test;
    import rce_pkg::*;
    // ====
    // Signals; all strobes tied on, lanes are not the subject here
    logic        MCLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [3:0]  PSTRB = 4'hF;
    logic        PREADY;
    logic [31:0] PRDATA;
    logic        PSLVERR;
    logic        RX_CHAN_VALID = 1'b0;
    rce_chan_t   RX_CHAN_NUM = 7'h00;
    logic        RX_CHAN_ENABLED;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    rce_word_t   pat [8];

    rce_bank dut_u (.MCLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PSTRB, .PREADY, .PRDATA, .PSLVERR, .RX_CHAN_VALID,
        .RX_CHAN_NUM, .RX_CHAN_ENABLED);

    // 50 MHz clock and a watchdog well above the expected run
    always #10 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 8000) begin
            bad_count++;
            finish_test();
        end
    end

    // ====
    // Shared tasks
    task automatic finish_test;
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; an idle cycle after it avoids double drives
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        q = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
    endtask

    // Query one channel; the answer stands in the cycle after, so it is
    // read mid-cycle, away from the edge that clears it again
    task automatic query(input int c, output logic en);
        RX_CHAN_VALID <= 1'b1;
        RX_CHAN_NUM <= 7'(c);
        @(posedge MCLK);
        RX_CHAN_VALID <= 1'b0;
        @(negedge MCLK);
        en = RX_CHAN_ENABLED;
        @(posedge MCLK);
    endtask

    task automatic do_reset;
        RST_N <= 1'b0;
        repeat (12) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
    endtask

    // ====
    // Scenarios
    task automatic t_reset_values;
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, q, e);
            check("reset_val", q, 32'h0);
        end
    endtask

    task automatic t_regs;
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 8; i++) begin
            pat[i] = 16'hA5C3 ^ 16'(i * 16'h1357);
            apb(1'b1, 8'(4 * i), {16'hFFFF, pat[i]}, q, e);
        end
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, q, e);
            check("part_rw", q, {16'h0000, pat[i]});
        end
        apb(1'b1, 8'h40, 32'hFFFF, q, e);
        check("unmapped_err", 32'(e), 32'h1);
        apb(1'b0, 8'h06, 32'h0, q, e);
        check("misalign_err", 32'(e), 32'h1);
        check("misalign_rd", q, 32'h0);
    endtask

    // Mode 0 selection off, 1 wide map, 2..5 narrow map per block pair
    task automatic t_modes;
        logic [31:0] q;
        logic        e;
        logic        en;
        logic        exp;
        int          b;
        for (int m = 0; m < 6; m++) begin
            b = (m > 1) ? m - 2 : 0;
            apb(1'b1, 8'h20, 32'((m == 0) ? 0 : (m == 1) ? 3
                : ((3 - b) << 6) | (b << 4) | 1), q, e);
            for (int c = 0; c < 128; c++) begin
                query(c, en);
                if (m == 0) exp = 1'b1;
                else if (m == 1) exp = pat[c / 16][c % 16];
                else if (c / 16 == 2 * b) exp = pat[0][c % 16];
                else if (c / 16 == 7 - 2 * b) exp = pat[1][c % 16];
                else exp = 1'b0;
                check("chan_en", 32'(en), 32'(exp));
            end
        end
    endtask

    // ====
    // Main sequence, with a second reset in mid-run
    initial begin
        do_reset();
        t_reset_values();
        t_regs();
        t_modes();
        do_reset();
        t_reset_values();
        finish_test();
    end
endmodule
